//--- sar_adc_regs.vh
/*
 * Constants of the serial conversion sequencer: state codes, word widths,
 * reset values and sequence counts.
 * Assumes it is included by bare name into the sequencer's design files.
 */
`ifndef SAR_ADC_REGS_VH
`define SAR_ADC_REGS_VH

// ==================================================
// sequencer states
`define ST_IDLE 3'h0
`define ST_CFG 3'h1
`define ST_ACQ 3'h2
`define ST_CONV 3'h3
`define ST_DONE 3'h4

// ==================================================
// widths and field positions
`define RES_W 10
`define RES_MSB 4'h9
`define CFG_BIT_MODE 1'h0
`define CFG_BIT_POL 1'h1
`define SYNC_W 4
`define SYNC_SCLK 2
`define SYNC_CSN 3
`define SYNC_DIN 1
`define SYNC_CMP 0

// ==================================================
// reset and trial values
`define RES_RST 10'h000
`define TRIAL_MSB 10'h200
`define SYNC_RST 4'h8

// ==================================================
// sequence counts, in serial clock periods
`define CFG_BITS 2'h2
`define ACQ_RISES 1'h1
`define TOTAL_SCLK 15

`endif

//--- pin_sync.v
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous to clk_in; only the second stage is read.
 */
`timescale 1ns/1ns
module pin_sync #(
	parameter WIDTH = 4,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	input wire clk_in,
	input wire rst_in,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] sync_ff;

	always @(posedge clk_in) begin
		if (rst_in) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule

//--- sar_adc_serial_sequencer.v
/*
 * Serial control and conversion sequencer of a 10-bit successive
 * approximation converter with a two-input front-end multiplexer.
 * Assumes: select_bar_n_in, serial_clock_in, serial_in and comparator_in
 * are asynchronous pins; the serial clock is far slower than clk_in
 * (at least six clk_in periods per half period); the analog side
 * closes its sample switches on track_out, holds both inputs at once when
 * it falls, and settles comparator_in well within half a serial period.
 */
`timescale 1ns/1ns
`include "sar_adc_regs.vh"

// What this block does
// (RULE1) leading zeros before start bit are ignored
// (RULE2) select low plus start bit begins conversion
// (RULE3) two config bits follow start, latched
// (RULE4) config bit zero differential, one single-ended
// (RULE5) polarity bit chooses which input is positive
// (RULE6) differential inputs held in one instant
// (RULE7) acquisition spans one and a half periods
// (RULE8) msb tried first, decision driven at once
// (RULE9) remaining bits resolved and shifted out serially
// (RULE10) whole conversion takes fifteen serial periods
// (RULE11) result is straight binary
// (RULE12) host raises select between conversions
// (RULE13) output floats while select is high
// (RULE14) select high then low rearms start
// (RULE15) sample input on rise, update output on fall
// (RULE16) select rising mid-conversion abandons it
module sar_adc_serial_sequencer (
	input wire clk_in,
	input wire rst_in,
	input wire select_bar_n_in,
	input wire serial_clock_in,
	input wire serial_in,
	input wire comparator_in,
	output reg serial_out,
	output reg serial_out_en_out,
	output reg track_out,
	output reg mux_single_ended_out,
	output reg mux_b_positive_out,
	output reg [`RES_W-1:0] dac_code_out,
	output reg [`RES_W-1:0] result_out,
	output reg done_out
);
	// ==================================================
	// pin synchronisers
	wire [`SYNC_W-1:0] pins_sync;
	wire sclk_s;
	wire csn_s;
	wire din_s;
	wire cmp_s;

	pin_sync #(
		.WIDTH(`SYNC_W),
		.RST_VAL(`SYNC_RST)
	) u_pin_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.async_in({select_bar_n_in, serial_clock_in, serial_in, comparator_in}),
		.sync_out(pins_sync)
	);

	assign sclk_s = pins_sync[`SYNC_SCLK];
	assign csn_s = pins_sync[`SYNC_CSN];
	assign din_s = pins_sync[`SYNC_DIN];
	assign cmp_s = pins_sync[`SYNC_CMP];

	// ==================================================
	// serial clock edge detection
	reg sclk_prev_ff;
	wire sclk_rise;
	wire sclk_fall;

	always @(posedge clk_in) begin
		if (rst_in) begin
			sclk_prev_ff <= 1'b0;
		end else begin
			sclk_prev_ff <= sclk_s;
		end
	end

	assign sclk_rise = sclk_s & ~sclk_prev_ff; // see (RULE15)
	assign sclk_fall = ~sclk_s & sclk_prev_ff; // see (RULE15)

	// ==================================================
	// sequencer state
	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg [1:0] cfg_cnt_ff;
	reg [1:0] nxt_cfg_cnt;
	reg acq_rise_ff;
	reg nxt_acq_rise;
	reg [3:0] bit_idx_ff;
	reg [3:0] nxt_bit_idx;
	reg nxt_serial_out;
	reg nxt_serial_out_en;
	reg nxt_track;
	reg nxt_mux_single;
	reg nxt_mux_b_pos;
	reg [`RES_W-1:0] nxt_dac_code;
	reg [`RES_W-1:0] nxt_result;
	reg nxt_done;

	always @* begin
		nxt_state = state_ff;
		nxt_cfg_cnt = cfg_cnt_ff;
		nxt_acq_rise = acq_rise_ff;
		nxt_bit_idx = bit_idx_ff;
		nxt_serial_out = serial_out;
		nxt_serial_out_en = serial_out_en_out;
		nxt_track = track_out;
		nxt_mux_single = mux_single_ended_out;
		nxt_mux_b_pos = mux_b_positive_out;
		nxt_dac_code = dac_code_out;
		nxt_result = result_out;
		nxt_done = 1'b0;
		if (csn_s) begin
			// deselect aborts anything in flight and rearms
			nxt_state = `ST_IDLE; // see (RULE16) see (RULE14) see (RULE12)
			nxt_serial_out_en = 1'b0; // see (RULE13)
			nxt_serial_out = 1'b0;
			nxt_track = 1'b0; // see (RULE16)
			nxt_cfg_cnt = 2'h0;
			nxt_acq_rise = 1'b0;
		end else begin
			case (state_ff)
				`ST_IDLE: begin
					// zeros leave us here; the first one is the start bit
					if (sclk_rise && din_s) begin
						nxt_state = `ST_CFG; // see (RULE1) see (RULE2)
						nxt_cfg_cnt = 2'h0;
					end
				end
				`ST_CFG: begin
					if (sclk_rise) begin
						// widened on purpose: the field position is one bit, the count two
						if (cfg_cnt_ff == {1'b0, `CFG_BIT_MODE}) begin
							nxt_mux_single = din_s; // see (RULE3) see (RULE4)
							nxt_cfg_cnt = cfg_cnt_ff + 2'h1;
						end else begin
							nxt_mux_b_pos = din_s; // see (RULE3) see (RULE5)
							nxt_cfg_cnt = `CFG_BITS;
							nxt_state = `ST_ACQ;
							// tracking opens on the polarity rise
							nxt_track = 1'b1; // see (RULE7)
							nxt_acq_rise = 1'b0;
						end
					end
				end
				`ST_ACQ: begin
					if (sclk_rise) begin
						nxt_acq_rise = `ACQ_RISES;
					end else if (sclk_fall && acq_rise_ff) begin
						// one rise plus half a period after opening: hold
						nxt_track = 1'b0; // see (RULE7) see (RULE6)
						nxt_dac_code = `TRIAL_MSB; // see (RULE8)
						nxt_result = `RES_RST;
						nxt_bit_idx = `RES_MSB;
						nxt_serial_out_en = 1'b1;
						nxt_serial_out = 1'b0;
						nxt_state = `ST_CONV;
					end
				end
				`ST_CONV: begin
					if (sclk_fall) begin
						// comparator high means trial level below input
						nxt_result[bit_idx_ff] = cmp_s; // see (RULE8) see (RULE11)
						nxt_dac_code[bit_idx_ff] = cmp_s;
						nxt_serial_out = cmp_s; // see (RULE9) see (RULE15)
						if (bit_idx_ff == 4'h0) begin
							nxt_state = `ST_DONE; // see (RULE10)
							nxt_done = 1'b1;
						end else begin
							nxt_dac_code[bit_idx_ff-4'h1] = 1'b1; // see (RULE9)
							nxt_bit_idx = bit_idx_ff - 4'h1;
						end
					end
				end
				`ST_DONE: begin
					// lsb stays on the pin; a new start needs deselect
					nxt_state = `ST_DONE; // see (RULE12)
				end
				default: begin
					nxt_state = `ST_IDLE;
					nxt_serial_out_en = 1'b0;
					nxt_track = 1'b0;
				end
			endcase
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			state_ff <= `ST_IDLE;
			cfg_cnt_ff <= 2'h0;
			acq_rise_ff <= 1'b0;
			bit_idx_ff <= 4'h0;
			serial_out <= 1'b0;
			serial_out_en_out <= 1'b0;
			track_out <= 1'b0;
			mux_single_ended_out <= 1'b0;
			mux_b_positive_out <= 1'b0;
			dac_code_out <= `RES_RST;
			result_out <= `RES_RST;
			done_out <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cfg_cnt_ff <= nxt_cfg_cnt;
			acq_rise_ff <= nxt_acq_rise;
			bit_idx_ff <= nxt_bit_idx;
			serial_out <= nxt_serial_out;
			serial_out_en_out <= nxt_serial_out_en;
			track_out <= nxt_track;
			mux_single_ended_out <= nxt_mux_single;
			mux_b_positive_out <= nxt_mux_b_pos;
			dac_code_out <= nxt_dac_code;
			result_out <= nxt_result;
			done_out <= nxt_done;
		end
	end
endmodule

//--- sar_adc_serial_sequencer_properties.sv
/* Port checker of the serial conversion sequencer.
   Assumes it is bound to the sequencer and sees its ports only. */
`timescale 1ns/1ns
module sar_adc_serial_sequencer_properties (
	input wire clk_in,
	input wire rst_in,
	input wire select_bar_n_in,
	input wire serial_clock_in,
	input wire serial_out,
	input wire serial_out_en_out,
	input wire track_out,
	input wire mux_single_ended_out,
	input wire mux_b_positive_out,
	input wire [9:0] dac_code_out,
	input wire [9:0] result_out,
	input wire done_out
);
	// ==========
	// properties
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	property p_float; select_bar_n_in [*6] |-> !serial_out_en_out; endproperty
	a_float: assert property (p_float) else $error("output driven while deselected");
	property p_en_sel; $rose(serial_out_en_out) |-> !select_bar_n_in; endproperty
	a_en_sel: assert property (p_en_sel) else $error("output enabled without select");
	property p_hold; $fell(track_out) && serial_out_en_out |-> dac_code_out == 10'h200 && !serial_out; endproperty
	a_hold: assert property (p_hold) else $error("msb trial not set at hold");
	property p_acq; $rose(track_out) |-> track_out [*8]; endproperty
	a_acq: assert property (p_acq) else $error("tracking too short");
	property p_mux; serial_out_en_out |-> $stable({mux_single_ended_out, mux_b_positive_out}); endproperty
	a_mux: assert property (p_mux) else $error("mux setting moved in conversion");
	property p_lsb; done_out |-> serial_out == result_out[0] && dac_code_out == result_out; endproperty
	a_lsb: assert property (p_lsb) else $error("last bit not on output");
	property p_pulse; done_out |=> !done_out; endproperty
	a_pulse: assert property (p_pulse) else $error("done longer than a cycle");
	property p_edge; $changed(serial_out) && serial_out_en_out |-> !serial_clock_in; endproperty
	a_edge: assert property (p_edge) else $error("output moved while clock high");
endmodule

//--- sar_adc_host_model.sv
/* Host serial port model: select, serial clock and data toward the converter.
   Assumes the bench clock runs at 4 ns; serial clock is 12 cycles a period. */
`timescale 1ns/1ns
module sar_adc_host_model (
	input wire clk_in,
	input wire data_in,
	output reg select_bar_n_out,
	output reg serial_clock_out,
	output reg serial_out
);
	integer k;
	integer j;
	initial begin
		select_bar_n_out = 1'b1;
		serial_clock_out = 1'b0;
		serial_out = 1'b0;
	end
	// ==========
	// one frame; select stays low afterwards
	task convert(input [3:0] zeros, input cfg, input pol, input [4:0] nclk, output [9:0] res);
		begin
			res = 10'h000;
			select_bar_n_out <= 1'b0;
			repeat (6) @(posedge clk_in);
			for (k = 0; k < zeros + nclk; k = k + 1) begin
				j = k - zeros;
				// data changes while clock low; toggling filler after the config bits
				serial_out <= (j < 0) ? 1'b0 : (j == 0) ? 1'b1 : (j == 1) ? cfg : (j == 2) ? pol : k[0];
				repeat (6) @(posedge clk_in);
				serial_clock_out <= 1'b1;
				if (j >= 5 && j < 15)
					res[14-j] = data_in;
				repeat (6) @(posedge clk_in);
				serial_clock_out <= 1'b0;
			end
		end
	endtask
	task deselect;
		begin
			repeat (6) @(posedge clk_in);
			select_bar_n_out <= 1'b1;
			serial_out <= ~serial_out;
			repeat (8) @(posedge clk_in);
		end
	endtask
endmodule

//--- sar_adc_serial_sequencer_test.sv
/* Self-checking bench of the serial conversion sequencer.
   Assumes the host model and the port checker are compiled first. */
`timescale 1ns/1ns
module sar_adc_serial_sequencer_test;
	reg clk_in = 1'b0;
	reg rst_in = 1'b1;
	reg comparator_in = 1'b0;
	reg [9:0] vin = 10'h000;
	reg [9:0] got;
	reg [11:0] rows [0:5];
	integer failures = 0;
	integer total_checks = 0;
	integer i;
	wire select_bar_n_in, serial_clock_in, serial_in, serial_out, serial_out_en_out, track_out, done_out;
	wire mux_single_ended_out, mux_b_positive_out;
	wire [9:0] dac_code_out, result_out;
	wire dout_line = serial_out_en_out ? serial_out : 1'bz;
	sar_adc_serial_sequencer dut (.clk_in(clk_in), .rst_in(rst_in), .select_bar_n_in(select_bar_n_in),
		.serial_clock_in(serial_clock_in), .serial_in(serial_in), .comparator_in(comparator_in),
		.serial_out(serial_out), .serial_out_en_out(serial_out_en_out), .track_out(track_out),
		.mux_single_ended_out(mux_single_ended_out), .mux_b_positive_out(mux_b_positive_out),
		.dac_code_out(dac_code_out), .result_out(result_out), .done_out(done_out));
	sar_adc_host_model host (.clk_in(clk_in), .data_in(dout_line), .select_bar_n_out(select_bar_n_in),
		.serial_clock_out(serial_clock_in), .serial_out(serial_in));
	// analog stand-in: one when the trial code is not above the input code
	always @(posedge clk_in)
		comparator_in <= (dac_code_out <= vin);
	initial begin
		forever #2 clk_in = ~clk_in;
	end
	task check(input [9:0] act, input [9:0] exp);
		begin
			total_checks = total_checks + 1;
			if (act !== exp) begin
				failures = failures + 1;
				$display("mismatch at %0t: got %h expected %h", $time, act, exp);
			end
		end
	endtask
	task report_and_stop;
		begin
			$display("checks %0d failures %0d", total_checks, failures);
			if (failures == 0 && total_checks > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	// ==========
	// main sequence
	initial begin
		rows[0] = {2'b00, 10'h000};
		rows[1] = {2'b01, 10'h200};
		rows[2] = {2'b10, 10'h3FF};
		rows[3] = {2'b11, 10'h155};
		rows[4] = {2'b00, 10'h001};
		rows[5] = {2'b10, 10'h3FE};
		repeat (10) @(posedge clk_in);
		check({7'h00, serial_out_en_out, track_out, done_out}, 10'h000);
		rst_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		for (i = 0; i < 6; i = i + 1) begin
			vin <= rows[i][9:0];
			host.convert(i[3:0], rows[i][11], rows[i][10], 5'hF, got);
			check(got, rows[i][9:0]);
			check(result_out, rows[i][9:0]);
			check({8'h00, mux_single_ended_out, mux_b_positive_out}, {8'h00, rows[i][11:10]});
			host.deselect;
		end
		// second start while still selected must be ignored
		vin <= 10'h0F1;
		host.convert(4'h2, 1'b0, 1'b1, 5'hF, got);
		check(got, 10'h0F1);
		vin <= 10'h00E;
		host.convert(4'h0, 1'b1, 1'b0, 5'hF, got);
		check(result_out, 10'h0F1);
		check(got, 10'h3FF);
		host.deselect;
		check({9'h000, serial_out_en_out}, 10'h000);
		// deselect while tracking must open the sample switch
		host.convert(4'h0, 1'b0, 1'b1, 5'h3, got);
		check({9'h000, track_out}, 10'h001);
		host.deselect;
		check({9'h000, track_out}, 10'h000);
		// abort mid-conversion, then a fresh one
		host.convert(4'h1, 1'b1, 1'b1, 5'h9, got);
		host.deselect;
		check({8'h00, serial_out_en_out, track_out}, 10'h000);
		vin <= 10'h123;
		host.convert(4'h0, 1'b0, 1'b0, 5'hF, got);
		check(got, 10'h123);
		host.deselect;
		// reset in mid-conversion clears the outputs and rearms the sequencer
		vin <= 10'h2A5;
		host.convert(4'h0, 1'b1, 1'b0, 5'h8, got);
		rst_in <= 1'b1;
		repeat (10) @(posedge clk_in);
		check({7'h00, serial_out_en_out, track_out, mux_single_ended_out}, 10'h000);
		rst_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		host.convert(4'h0, 1'b1, 1'b0, 5'hF, got);
		check(got, 10'h2A5);
		check({8'h00, mux_single_ended_out, mux_b_positive_out}, 10'h002);
		host.deselect;
		report_and_stop;
	end
	initial begin
		repeat (100000) @(posedge clk_in);
		failures = failures + 1;
		report_and_stop;
	end
endmodule
bind sar_adc_serial_sequencer sar_adc_serial_sequencer_properties chk (.*);
